// File: src/voice_store_pkg.sv
// shared constants of the voice store host port
package voice_store_pkg;
  localparam int          FRAME_BITS        = 8;
  localparam int          SEG_LEN_DEFAULT   = 64;
  localparam int          DIV_DEFAULT       = 4;
  localparam logic [7:0]  OP_IDLE           = 8'h00;
  localparam logic [7:0]  OP_RECORD         = 8'h01;
  localparam logic [7:0]  OP_PLAY           = 8'h02;
  localparam logic [7:0]  OP_FORWARD        = 8'h03;
  localparam logic [7:0]  OP_STOP           = 8'h04;
  localparam logic [7:0]  OP_POWER_UP       = 8'h05;
  localparam logic [7:0]  STATUS_RESET      = 8'h00;
  localparam int          STATUS_ATTN_BIT   = 0;
  localparam int          STATUS_BUSY_BIT   = 1;
  localparam int          STATUS_WARN_BIT   = 2;
  localparam int          STATUS_EXT_BIT    = 3;
  localparam int          EXT_TIMEOUT       = 64;
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_RECORD  = 2'b01,
    ST_PLAY    = 2'b11,
    ST_FORWARD = 2'b10
  } op_state_type;
endpackage

// File: src/spi_link.sv
// spi shift logic on the serial clock domain
`timescale 1ns/1ps
module spi_link #(
  parameter int WIDTH = 8
) (
  input  wire logic             sclk,
  input  wire logic             cs_n,
  input  wire logic             serial_in,
  output logic                  serial_out,
  output logic                  serial_out_oe,
  output logic [WIDTH-1:0]      rx_word,
  output logic                  rx_toggle,
  input  wire logic [WIDTH-1:0] tx_word
);
  typedef struct packed {
    logic [WIDTH-1:0]         shift;
    logic [$clog2(WIDTH)-1:0] cnt;
    logic [WIDTH-1:0]         word;
    logic                     tog;
  } rx_state_type;

  // toggle needs a known start; cs high must not clear it or a false command follows
  rx_state_type rx_r = '0;
  rx_state_type rx_nxt;
  logic [WIDTH-1:0] tx_r;
  logic             out_r;
  logic             first_r;

  initial begin
    if (WIDTH < 2) $error("spi_link needs at least two bits");
  end

  // cs high acts as the frame reset, so no edge outside a frame is needed
  always_comb begin
    rx_nxt = rx_r;
    rx_nxt.shift = {rx_r.shift[WIDTH-2:0], serial_in};
    if (rx_r.cnt == ($clog2(WIDTH))'(WIDTH - 1)) begin
      rx_nxt.cnt = '0;
      rx_nxt.word = {rx_r.shift[WIDTH-2:0], serial_in};
      rx_nxt.tog = ~rx_r.tog;
    end else begin
      rx_nxt.cnt = rx_r.cnt + 1'b1;
    end
  end

  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      rx_r.shift <= '0;
      rx_r.cnt   <= '0;
    end else begin
      rx_r.shift <= rx_nxt.shift;
      rx_r.cnt   <= rx_nxt.cnt;
      rx_r.word  <= rx_nxt.word;
      rx_r.tog   <= rx_nxt.tog;
    end
  end

  // status shifts msb first; first bit stands from the select edge
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      tx_r    <= '0;
      out_r   <= 1'b0;
      first_r <= 1'b1;
    end else begin
      first_r <= 1'b0;
      if (first_r) begin
        out_r <= tx_word[WIDTH-2];
        tx_r  <= tx_word << 2;
      end else if (rx_r.cnt == '0) begin
        out_r <= tx_word[WIDTH-1];
        tx_r  <= {tx_word[WIDTH-2:0], 1'b0};
      end else begin
        out_r <= tx_r[WIDTH-1];
        tx_r  <= {tx_r[WIDTH-2:0], 1'b0};
      end
    end
  end

  // msb must stand before the first falling edge of a frame
  assign serial_out    = first_r ? tx_word[WIDTH-1] : out_r;
  assign serial_out_oe = ~cs_n;
  assign rx_word       = rx_r.word;
  assign rx_toggle     = rx_r.tog;
endmodule

// File: src/voice_store_host_port.sv
// host pin logic of the voice store: spi commands, handshakes, busy
// Overview of operation
// - segment-end warning low signals the active segment nearing its end
// - attention output is open drain, pulled low only, never driven high
// - attention asserted at end of message or memory overflow
// - external sample clock accepted instead of the internal sampling clock
// - serial input captured on rising serial clock edge
// - serial output updated on falling serial clock edge
// - host pulls chip select low to make the device take part
// - chip select high: serial output floats, serial input ignored
// - reset low clears address registers and restores power-up defaults
// - quiet-passage flag low while the squelch is active
// - warning rests high, falls at half segment, rises at segment end
// - commands taken during warning low; later ones wait for next cycle
// - busy low during record, play or forward, floating otherwise
// - attention also asserted after power-up command on low supply
`timescale 1ns/1ps
module voice_store_host_port #(
  parameter int SEG_LEN = voice_store_pkg::SEG_LEN_DEFAULT,
  parameter int DIV     = voice_store_pkg::DIV_DEFAULT
) (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic reset_n,
  input  wire logic sclk,
  input  wire logic cs_n,
  input  wire logic serial_in,
  output logic      serial_out,
  output logic      serial_out_oe,
  output logic      segment_end_warning_n,
  output logic      attention_n_out,
  output logic      attention_n_oe,
  output logic      busy_n_out,
  output logic      busy_n_oe,
  output logic      quiet_passage_flag_n,
  input  wire logic external_sample_clock,
  input  wire logic squelch_active,
  input  wire logic low_supply,
  input  wire logic message_end,
  output logic      sample_tick,
  output logic [7:0] address
);
  localparam int SEGW = $clog2(SEG_LEN + 1);
  localparam int DIVW = $clog2(DIV + 1);
  localparam int EXTW = $clog2(voice_store_pkg::EXT_TIMEOUT + 1);

  initial begin
    if (SEG_LEN < 2) $error("segment length must be at least two samples");
    if (DIV < 1) $error("divider must be at least one");
  end

  typedef struct packed {
    logic [2:0]                    rst_sync;
    logic [1:0]                    tog_sync;
    logic                          tog_seen;
    logic [1:0]                    ext_sync;
    logic                          ext_prev;
    logic [EXTW-1:0]               ext_age;
    logic [DIVW-1:0]               div_cnt;
    logic                          tick;
    logic [1:0]                    sq_sync;
    logic                          sq_flag;
    logic [1:0]                    lowv_sync;
    logic [1:0]                    end_sync;
    voice_store_pkg::op_state_type op;
    logic [SEGW-1:0]               pos;
    logic                          warn;
    logic                          attn;
    logic [7:0]                    pend;
    logic                          pend_v;
    logic [7:0]                    addr;
  } core_state_type;

  core_state_type s_r;
  core_state_type s_nxt;
  logic [7:0] rx_word;
  logic       rx_toggle;
  logic [7:0] status_word;
  logic       link_cs_n;
  logic       aclr_r;

  // async assert, sync release of the pin reset
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      aclr_r <= 1'b1;
    end else begin
      aclr_r <= 1'b0;
    end
  end

  // held reset also deselects the link so traffic is ignored
  assign link_cs_n = cs_n | ~reset_n;

  spi_link #(
    .WIDTH (voice_store_pkg::FRAME_BITS)
  ) u_link (
    .sclk          (sclk),
    .cs_n          (link_cs_n),
    .serial_in     (serial_in),
    .serial_out    (serial_out),
    .serial_out_oe (serial_out_oe),
    .rx_word       (rx_word),
    .rx_toggle     (rx_toggle),
    .tx_word       (status_word)
  );

  // status word is quasi-static; sampled by the link at frame start and again at each word boundary
  always_comb begin
    status_word = voice_store_pkg::STATUS_RESET;
    status_word[voice_store_pkg::STATUS_ATTN_BIT] = s_r.attn;
    status_word[voice_store_pkg::STATUS_BUSY_BIT] =
      (s_r.op != voice_store_pkg::ST_IDLE);
    status_word[voice_store_pkg::STATUS_WARN_BIT] = s_r.warn;
    status_word[voice_store_pkg::STATUS_EXT_BIT] =
      (s_r.ext_age != '0);
  end

  function automatic voice_store_pkg::op_state_type op_decode(
    input logic [7:0] code,
    input voice_store_pkg::op_state_type cur
  );
    unique case (code)
      voice_store_pkg::OP_RECORD:  op_decode = voice_store_pkg::ST_RECORD;
      voice_store_pkg::OP_PLAY:    op_decode = voice_store_pkg::ST_PLAY;
      voice_store_pkg::OP_FORWARD: op_decode = voice_store_pkg::ST_FORWARD;
      voice_store_pkg::OP_STOP:    op_decode = voice_store_pkg::ST_IDLE;
      default:                     op_decode = cur;
    endcase
  endfunction

  always_comb begin
    logic new_cmd;
    logic ext_edge;
    logic seg_done;
    logic take;
    logic [7:0] cmd;
    new_cmd  = 1'b0;
    ext_edge = 1'b0;
    seg_done = 1'b0;
    take     = 1'b0;
    cmd      = voice_store_pkg::OP_IDLE;
    s_nxt = s_r;
    s_nxt.rst_sync  = {s_r.rst_sync[1:0], 1'b0};
    s_nxt.tog_sync  = {s_r.tog_sync[0], rx_toggle};
    s_nxt.ext_sync  = {s_r.ext_sync[0], external_sample_clock};
    s_nxt.sq_sync   = {s_r.sq_sync[0], squelch_active};
    s_nxt.lowv_sync = {s_r.lowv_sync[0], low_supply};
    s_nxt.end_sync  = {s_r.end_sync[0], message_end};
    s_nxt.sq_flag   = s_r.sq_sync[1];
    new_cmd = (s_r.tog_sync[1] != s_r.tog_seen);
    s_nxt.tog_seen = s_r.tog_sync[1];
    // external clock counts as present while its edges keep arriving
    s_nxt.ext_prev = s_r.ext_sync[1];
    ext_edge = s_r.ext_sync[1] & ~s_r.ext_prev;
    if (ext_edge) begin
      s_nxt.ext_age = EXTW'(voice_store_pkg::EXT_TIMEOUT);
    end else if (s_r.ext_age != '0) begin
      s_nxt.ext_age = s_r.ext_age - 1'b1;
    end
    s_nxt.tick = 1'b0;
    if (s_r.ext_age != '0) begin
      if (ext_edge) begin
        if (s_r.div_cnt == DIVW'(DIV - 1)) begin
          s_nxt.div_cnt = '0;
          s_nxt.tick = 1'b1;
        end else begin
          s_nxt.div_cnt = s_r.div_cnt + 1'b1;
        end
      end
    end else if (s_r.div_cnt == DIVW'(DIV - 1)) begin
      s_nxt.div_cnt = '0;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.div_cnt = s_r.div_cnt + 1'b1;
    end
    // commands land in a one-deep holding slot
    if (new_cmd) begin
      s_nxt.pend   = rx_word;
      s_nxt.pend_v = 1'b1;
    end
    if (s_r.pend_v) begin
      cmd = s_r.pend;
    end
    if (s_r.pend_v && cmd == voice_store_pkg::OP_POWER_UP) begin
      take = 1'b1;
      if (s_r.lowv_sync[1]) begin
        s_nxt.attn = 1'b1;
      end
    end else if (s_r.pend_v && s_r.op == voice_store_pkg::ST_IDLE) begin
      take = 1'b1;
      s_nxt.op  = op_decode(cmd, s_r.op);
      s_nxt.pos = '0;
    end
    // running: a held command other than power-up acts only inside the warning window
    seg_done = s_r.tick && (s_r.pos == SEGW'(SEG_LEN - 1));
    if (s_r.op != voice_store_pkg::ST_IDLE && s_r.tick) begin
      s_nxt.pos = s_r.pos + 1'b1;
      if (s_r.pos == SEGW'(SEG_LEN / 2 - 1)) begin
        s_nxt.warn = 1'b1;
      end
      if (seg_done) begin
        s_nxt.pos  = '0;
        s_nxt.warn = 1'b0;
        if (s_r.addr == 8'hFF) begin
          s_nxt.attn = 1'b1;
          s_nxt.op   = voice_store_pkg::ST_IDLE;
        end else begin
          s_nxt.addr = s_r.addr + 8'h01;
        end
      end
    end
    if (s_r.op != voice_store_pkg::ST_IDLE && s_r.pend_v && s_r.warn && !take) begin
      take = 1'b1;
      s_nxt.op = op_decode(cmd, s_r.op);
    end
    if (s_r.end_sync[1] && s_r.op != voice_store_pkg::ST_IDLE) begin
      s_nxt.attn = 1'b1;
      s_nxt.op   = voice_store_pkg::ST_IDLE;
      s_nxt.warn = 1'b0;
    end
    // any way of stopping leaves the warning at rest
    if (s_nxt.op == voice_store_pkg::ST_IDLE) begin
      s_nxt.warn = 1'b0;
    end
    // a fresh command this cycle refills the slot; set wins over the take
    if (take && !new_cmd) begin
      s_nxt.pend_v = 1'b0;
    end
    // attention clears when the host reads status over a new frame
    if (new_cmd && !(s_nxt.attn && !s_r.attn)) begin
      s_nxt.attn = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || aclr_r) begin
      s_r <= '0;
      s_r.op <= voice_store_pkg::ST_IDLE;
      s_r.tog_seen <= s_nxt.tog_seen;
      s_r.tog_sync <= s_nxt.tog_sync;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign segment_end_warning_n = ~s_r.warn;
  assign attention_n_out       = 1'b0;
  assign attention_n_oe        = s_r.attn;
  assign busy_n_out            = 1'b0;
  assign busy_n_oe             = (s_r.op != voice_store_pkg::ST_IDLE);
  assign quiet_passage_flag_n  = ~s_r.sq_flag;
  assign sample_tick           = s_r.tick;
  assign address               = s_r.addr;
endmodule

// File: test/voice_store_host_port_checker.sv
// pin-level assertions of the voice store host port
`timescale 1ns/1ps
module voice_store_host_port_checker (
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic       reset_n,
  input wire logic       cs_n,
  input wire logic       serial_out_oe,
  input wire logic       segment_end_warning_n,
  input wire logic       attention_n_out,
  input wire logic       attention_n_oe,
  input wire logic       busy_n_out,
  input wire logic       busy_n_oe,
  input wire logic       quiet_passage_flag_n,
  input wire logic       squelch_active,
  input wire logic       low_supply,
  input wire logic       message_end,
  input wire logic [7:0] address
);
  logic [3:0] cause_age_r;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // cycles since a cause of attention, saturating so stale causes stop counting
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cause_age_r <= 4'hF;
    end else if (message_end || low_supply || address == 8'hFF) begin
      cause_age_r <= 4'h0;
    end else if (cause_age_r != 4'hF) begin
      cause_age_r <= cause_age_r + 4'h1;
    end
  end
  property p_oe_cs; cs_n |-> !serial_out_oe; endproperty
  a_oe_cs: assert property (p_oe_cs) else $error("output on while deselected");
  property p_attn_od; attention_n_oe |-> !attention_n_out; endproperty
  a_attn_od: assert property (p_attn_od) else $error("attention driven high");
  property p_busy_low; busy_n_oe |-> !busy_n_out; endproperty
  a_busy_low: assert property (p_busy_low) else $error("busy driven high");
  property p_quiet_on; (squelch_active && reset_n) [*6] |-> !quiet_passage_flag_n; endproperty
  a_quiet_on: assert property (p_quiet_on) else $error("quiet flag not low");
  property p_quiet_off; (!squelch_active && reset_n) [*6] |-> quiet_passage_flag_n; endproperty
  a_quiet_off: assert property (p_quiet_off) else $error("quiet flag stuck low");
  property p_pin_reset;
    !reset_n |=> !busy_n_oe && segment_end_warning_n && address == 8'h00;
  endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("pin reset ignored");
  property p_warn_busy; $fell(segment_end_warning_n) |-> busy_n_oe; endproperty
  a_warn_busy: assert property (p_warn_busy) else $error("warning while idle");
  property p_warn_rest; $rose(busy_n_oe) |-> segment_end_warning_n; endproperty
  a_warn_rest: assert property (p_warn_rest) else $error("warning low at start");
  property p_warn_idle; !busy_n_oe |-> segment_end_warning_n; endproperty
  a_warn_idle: assert property (p_warn_idle) else $error("warning low while idle");
  property p_attn_cause; $rose(attention_n_oe) |-> cause_age_r < 4'hC; endproperty
  a_attn_cause: assert property (p_attn_cause) else $error("attention without cause");
endmodule

bind voice_store_host_port voice_store_host_port_checker u_voice_store_host_port_checker (.*);

// File: test/spi_host_model.sv
// host spi master model on the serial link
`timescale 1ns/1ps
module spi_host_model (
  output logic      sclk,
  output logic      cs_n,
  output logic      serial_in,
  input  wire logic serial_out
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    serial_in = 1'b0;
  end
  // sel low clocks the frame with chip select left high
  task automatic xfer(input logic [7:0] tx, input logic sel, output logic [7:0] rx);
    cs_n = !sel;
    for (int i = 7; i >= 0; i--) begin
      serial_in = tx[i];
      #62.5 sclk = 1'b1;
      rx[i] = serial_out;
      #62.5 sclk = 1'b0;
    end
    #62.5 cs_n = 1'b1;
    serial_in = ~tx[0];
  endtask
endmodule

// File: test/voice_store_host_port_tb_top.sv
// self-checking bench of the voice store host port
`timescale 1ns/1ps
module voice_store_host_port_tb_top;
  logic       core_clk = 1'b0;
  logic       rst = 1'b1;
  logic       reset_n = 1'b1;
  logic       external_sample_clock = 1'b0;
  logic       squelch_active = 1'b0;
  logic       low_supply = 1'b0;
  logic       message_end = 1'b0;
  logic       ext_on = 1'b1;
  wire        sclk;
  wire        cs_n;
  wire        serial_in;
  logic       serial_out, serial_out_oe, segment_end_warning_n, sample_tick;
  logic       attention_n_out, attention_n_oe, busy_n_out, busy_n_oe, quiet_passage_flag_n;
  logic [7:0] address;
  logic [7:0] rx;
  int         err_count = 0;
  int         compares = 0;
  int         cycles = 0;
  always #5 core_clk = ~core_clk;
  voice_store_host_port #(.SEG_LEN(8), .DIV(1)) u_voice_store_host_port (.*);
  spi_host_model u_spi_host_model (.*);
  // slow sample clock keeps a segment far longer than one frame
  // rising edges every 60 cycles stay inside the presence timeout
  always @(negedge core_clk) begin
    if (ext_on && cycles % 30 == 0) external_sample_clock <= ~external_sample_clock;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    if (err_count == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      err_count++;
      close_out();
    end
  end
  function automatic logic pick(input int s);
    case (s)
      0: return busy_n_oe;
      1: return segment_end_warning_n;
      2: return attention_n_oe;
      default: return quiet_passage_flag_n;
    endcase
  endfunction
  task automatic wait_lvl(input int s, input logic lvl);
    for (int i = 0; i < 3000 && pick(s) !== lvl; i++) @(negedge core_clk);
    check(pick(s), lvl);
  endtask
  task automatic send(input logic [7:0] op);
    u_spi_host_model.xfer(op, 1'b1, rx);
    repeat (2) @(negedge core_clk);
  endtask
  task automatic t_status;
    check({segment_end_warning_n, busy_n_oe, attention_n_oe, address}, 11'h400);
    send(voice_store_pkg::OP_IDLE);
    check(rx & 8'h0B, 8'h08);
    ext_on = 1'b0;
    repeat (150) @(negedge core_clk);
    check(sample_tick, 1'b1);
    send(voice_store_pkg::OP_IDLE);
    check(rx & 8'h08, 8'h00);
    ext_on = 1'b1;
    repeat (150) @(negedge core_clk);
    u_spi_host_model.xfer(voice_store_pkg::OP_PLAY, 1'b0, rx);
    repeat (10) @(negedge core_clk);
    check({busy_n_oe, serial_out_oe}, 8'h00);
  endtask
  task automatic t_queue;
    send(voice_store_pkg::OP_PLAY);
    wait_lvl(0, 1'b1);
    wait_lvl(1, 1'b0);
    wait_lvl(1, 1'b1);
    check(address, 8'h01);
    send(voice_store_pkg::OP_STOP);
    check(busy_n_oe, 1'b1);
    wait_lvl(1, 1'b0);
    wait_lvl(0, 1'b0);
  endtask
  task automatic t_attn;
    send(voice_store_pkg::OP_PLAY);
    wait_lvl(0, 1'b1);
    message_end = 1'b1;
    repeat (3) @(negedge core_clk);
    message_end = 1'b0;
    wait_lvl(2, 1'b1);
    send(voice_store_pkg::OP_STOP);
    check(attention_n_oe, 1'b0);
    wait_lvl(0, 1'b0);
    send(voice_store_pkg::OP_POWER_UP);
    repeat (10) @(negedge core_clk);
    check(attention_n_oe, 1'b0);
    low_supply = 1'b1;
    repeat (5) @(negedge core_clk);
    send(voice_store_pkg::OP_POWER_UP);
    wait_lvl(2, 1'b1);
    low_supply = 1'b0;
  endtask
  task automatic t_pins;
    squelch_active = 1'b1;
    wait_lvl(3, 1'b0);
    squelch_active = 1'b0;
    wait_lvl(3, 1'b1);
    send(voice_store_pkg::OP_PLAY);
    wait_lvl(1, 1'b0);
    reset_n = 1'b0;
    @(negedge core_clk);
    check({busy_n_oe, segment_end_warning_n, address}, 10'h100);
    u_spi_host_model.xfer(voice_store_pkg::OP_PLAY, 1'b1, rx);
    repeat (10) @(negedge core_clk);
    check(busy_n_oe, 1'b0);
    reset_n = 1'b1;
    repeat (3) @(negedge core_clk);
  endtask
  initial begin
    repeat (20) @(negedge core_clk);
    rst = 1'b0;
    repeat (200) @(negedge core_clk);
    t_status();
    t_queue();
    t_attn();
    t_pins();
    close_out();
  end
endmodule
